// ### design/adcbr_defines.vh
`ifndef ADCBR_DEFINES_VH
`define ADCBR_DEFINES_VH

`define ADCBR_RES_W        14
`define ADCBR_WORD_W       16
`define ADCBR_BYTE_W       8
`define ADCBR_PAD          2'b00
`define ADCBR_HI_MSB       15
`define ADCBR_HI_LSB       8
`define ADCBR_LO_MSB       7
`define ADCBR_LO_LSB       0
`define ADCBR_SIGN_BIT     13
`define ADCBR_RESET_US     10
`define ADCBR_CLK_MHZ      100
`define ADCBR_CONV_CYC     16'h0320
`define ADCBR_ZERO14       14'h0000
`define ADCBR_ZERO16       16'h0000
`define ADCBR_ZERO8        8'h00

`define ADCBR_ST_RESET     2'b00
`define ADCBR_ST_IDLE      2'b01
`define ADCBR_ST_CONV      2'b10

`endif

// ### design/adcbr_sync2.v
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser, one per bit
module adcbr_sync2 #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk) begin
        if (srst) begin
          meta_ff[i] <= 1'b1;
          sync_ff[i] <= 1'b1;
        end else begin
          meta_ff[i] <= d[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign q = sync_ff;

endmodule // adcbr_sync2

`default_nettype wire

// ### design/adcbr_top.v
`timescale 1ns/100ps
`default_nettype none
`include "adcbr_defines.vh"

module adcbr_top #(
  parameter integer RESET_CYC = `ADCBR_RESET_US * `ADCBR_CLK_MHZ,
  parameter integer CONV_CYC  = `ADCBR_CONV_CYC
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        sync_mode,
  input  wire        chip_sel_n,
  input  wire        out_en_n,
  input  wire        upper_byte_sel,
  input  wire        conv_begin_n,
  input  wire        done_flag_out_en_n,
  input  wire        bipolar_offset_pin,
  input  wire [13:0] sample_code,
  output reg  [7:0]  byte_out_bus,
  output wire        byte_out_oe,
  output wire        done_flag_out,
  output wire        done_flag_oe,
  output wire        result_valid,
  output wire        logic_ready
);

  localparam [1:0] ST_RESET = `ADCBR_ST_RESET;
  localparam [1:0] ST_IDLE  = `ADCBR_ST_IDLE;
  localparam [1:0] ST_CONV  = `ADCBR_ST_CONV;

  wire [6:0] pins_s;
  wire       mode_s  = pins_s[0];
  wire       cs_n_s  = pins_s[1];
  wire       oe_n_s  = pins_s[2];
  wire       upper_s = pins_s[3];
  wire       begin_n_s = pins_s[4];
  wire       den_n_s = pins_s[5];
  wire       bip_s   = pins_s[6];

  adcbr_sync2 #(
    .W (7)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .d    ({bipolar_offset_pin, done_flag_out_en_n, conv_begin_n, upper_byte_sel,
            out_en_n, chip_sel_n, sync_mode}),
    .q    (pins_s)
  );

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [31:0] cnt_ff;
  reg  [31:0] nxt_cnt;
  reg         begin_n_d_ff;
  reg  [13:0] code_ff;
  reg  [13:0] nxt_code;
  reg  [15:0] word_ff;
  reg  [15:0] nxt_word;
  reg         valid_ff;
  reg         nxt_valid;

  // sample taken on the start, converted code appears at completion
  reg  [13:0] held_ff;
  reg  [13:0] nxt_held;

  wire begin_fall = begin_n_d_ff & ~begin_n_s;
  // sync start also fires if chip select falls while start is low
  reg  cs_n_d_ff;
  wire cs_fall = cs_n_d_ff & ~cs_n_s;
  wire start   = mode_s ? ((begin_fall & ~cs_n_s) | (cs_fall & ~begin_n_s)) : begin_fall;

  wire converting = (state_ff != ST_IDLE);

  // coding: straight binary, or twos complement by flipping the sign bit
  wire [13:0] coded = bip_s ? {~held_ff[`ADCBR_SIGN_BIT], held_ff[12:0]} : held_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_code  = code_ff;
    nxt_held  = held_ff;
    nxt_word  = word_ff;
    nxt_valid = valid_ff;
    case (state_ff)
      ST_RESET: begin
        // ignore starts until internal reset time has elapsed
        if (cnt_ff >= RESET_CYC - 1) begin
          nxt_state = ST_IDLE;
          nxt_cnt   = 32'h0000_0000;
        end else begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end
      end
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_CONV;
          nxt_held  = sample_code;
          nxt_valid = 1'b0;
          nxt_cnt   = 32'h0000_0000;
        end
      end
      ST_CONV: begin
        if (cnt_ff >= CONV_CYC - 1) begin
          nxt_state = ST_IDLE;
          nxt_code  = coded;
          nxt_word  = {coded, `ADCBR_PAD};
          nxt_valid = 1'b1;
          nxt_cnt   = 32'h0000_0000;
        end else begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_ff  <= ST_RESET;
      cnt_ff    <= 32'h0000_0000;
      begin_n_d_ff <= 1'b1;
      cs_n_d_ff <= 1'b1;
      code_ff   <= `ADCBR_ZERO14;
      held_ff   <= `ADCBR_ZERO14;
      word_ff   <= `ADCBR_ZERO16;
      valid_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      begin_n_d_ff <= begin_n_s;
      cs_n_d_ff <= cs_n_s;
      code_ff   <= nxt_code;
      held_ff   <= nxt_held;
      word_ff   <= nxt_word;
      valid_ff  <= nxt_valid;
    end
  end

  // byte steering is registered; reads never disturb word_ff
  always @(posedge mclk) begin
    if (srst) begin
      byte_out_bus <= `ADCBR_ZERO8;
    end else if (upper_s) begin
      byte_out_bus <= word_ff[`ADCBR_LO_MSB:`ADCBR_LO_LSB];
    end else begin
      byte_out_bus <= word_ff[`ADCBR_HI_MSB:`ADCBR_HI_LSB];
    end
  end

  assign byte_out_oe = ~cs_n_s & ~oe_n_s;

  // sync: push-pull when enabled and chip selected; async: drive only the low level
  assign done_flag_out = mode_s ? ~converting : 1'b0;
  assign done_flag_oe  = mode_s ? (~den_n_s & ~cs_n_s)
                                : (~den_n_s & converting);
  assign result_valid  = valid_ff;
  assign logic_ready   = (state_ff != ST_RESET);

endmodule // adcbr_top

`default_nettype wire

// ### verif/adc_status_and_byte_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module adc_status_and_byte_readout_tb;
  logic        mclk = 0, srst = 1, sync_mode = 1, chip_sel_n = 1, out_en_n = 1;
  logic        upper_byte_sel = 0, conv_begin_n = 1, done_flag_out_en_n = 0;
  logic        bipolar_offset_pin = 0;
  logic [13:0] sample_code = 14'h0000;
  logic [15:0] w;
  wire  [7:0]  byte_out_bus, bus_seen;
  wire         byte_out_oe, done_flag_out, done_flag_oe, result_valid, logic_ready, eoc;
  int          error_cnt = 0, checked = 0, i;
  logic [15:0] tbl [5] = '{16'hbfff, 16'hbffe, 16'hffff, 16'h7000, 16'h2aaa};
  always #5 mclk = ~mclk;
  adcbr_top #(.RESET_CYC(10), .CONV_CYC(8)) dut (.*);
  adcbr_host_pins host (.byte_out_bus(byte_out_bus), .byte_out_oe(byte_out_oe),
    .done_flag_out(done_flag_out), .done_flag_oe(done_flag_oe), .sync_mode(sync_mode),
    .bus_pin(bus_seen), .eoc_pin(eoc));
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rd(logic h, logic [7:0] e);
    upper_byte_sel = h;
    chip_sel_n = 0;
    out_en_n = 0;
    cyc(4);
    `CHK("byte", e, bus_seen)
    chip_sel_n = 1;
    out_en_n = 1;
    cyc(4);
    `CHK("bus oe", 1'b0, byte_out_oe)
  endtask
  task automatic conclude();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    for (int t = 0; t < 5; t++) begin
      srst = 1;
      {sync_mode, bipolar_offset_pin} = tbl[t][15:14];
      cyc(6);
      srst = 0;
      cyc(2);
      `CHK("ready early", 1'b0, logic_ready)
      cyc(12);
      `CHK("ready", 1'b1, logic_ready)
      sample_code = tbl[t][13:0];
      chip_sel_n = !sync_mode;
      cyc(1);
      conv_begin_n = 0;
      cyc(4);
      `CHK("eoc busy", 1'b0, eoc)
      conv_begin_n = 1;
      i = 0;
      while (result_valid !== 1'b1 && i < 30) begin
        cyc(1);
        i++;
      end
      cyc(1);
      `CHK("eoc idle", 1'b1, eoc)
      chip_sel_n = 1;
      w = {bipolar_offset_pin ? {~sample_code[13], sample_code[12:0]} : sample_code, 2'b00};
      sample_code = ~sample_code;
      rd(0, w[15:8]);
      rd(1, w[7:0]);
      rd(0, w[15:8]);
      done_flag_out_en_n = 1;
      cyc(4);
      `CHK("done oe", 1'b0, done_flag_oe)
      done_flag_out_en_n = 0;
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule // adc_status_and_byte_readout_tb
bind adcbr_top adcbr_assertions chk (.*);
`default_nettype wire

// ### verif/adcbr_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adcbr_assertions (
  input wire       mclk, srst, sync_mode, chip_sel_n, out_en_n, upper_byte_sel,
  input wire       done_flag_out_en_n, result_valid, logic_ready, byte_out_oe,
  input wire       done_flag_out, done_flag_oe,
  input wire [7:0] byte_out_bus
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // four cycles of stable input cover the two-flop synchroniser
  a_bus_float: assert property ((chip_sel_n || out_en_n) [*4] |-> !byte_out_oe)
    else $error("data bus driven while deselected");
  a_bus_drive: assert property ((!chip_sel_n && !out_en_n) [*4] |-> byte_out_oe)
    else $error("data bus not driven while selected");
  a_async_drain: assert property (!sync_mode && done_flag_oe |-> !done_flag_out)
    else $error("done line driven high in open drain mode");
  a_done_off: assert property (done_flag_out_en_n [*4] |-> !done_flag_oe)
    else $error("done line driven while its enable is high");
  a_sync_cs: assert property (sync_mode && chip_sel_n [*4] |-> !done_flag_oe)
    else $error("done line driven without chip select");
  a_sync_idle: assert property (sync_mode && result_valid |-> done_flag_out)
    else $error("done line low while idle");
  a_async_idle: assert property (!sync_mode && result_valid |-> !done_flag_oe)
    else $error("done line pulled while idle");
  a_conv_len: assert property ($fell(result_valid) |->
    !result_valid [*6] ##[1:4] result_valid)
    else $error("conversion length wrong");
  a_reset_time: assert property ($fell(srst) |-> !logic_ready [*8])
    else $error("ready too early after reset");
  a_pad_zero: assert property (upper_byte_sel [*4] ##0 byte_out_oe |->
    byte_out_bus[1:0] == 2'b00)
    else $error("low byte pad bits not zero");
endmodule // adcbr_assertions
`default_nettype wire

// ### verif/adcbr_host_pins.sv
`timescale 1ns/100ps
`default_nettype none
module adcbr_host_pins (
  input  wire [7:0] byte_out_bus,
  input  wire       byte_out_oe, done_flag_out, done_flag_oe, sync_mode,
  output wire [7:0] bus_pin,
  output wire       eoc_pin
);
  // a released bus shows the inverse so a stale byte never passes
  assign bus_pin = byte_out_oe ? byte_out_bus : ~byte_out_bus;
  // pull-up holds the open drain line high in asynchronous mode
  assign eoc_pin = done_flag_oe ? done_flag_out : (sync_mode ? ~done_flag_out : 1'b1);
endmodule // adcbr_host_pins
`default_nettype wire
